/* File: rtl/vfp_pattern_gen.sv */
// vfp_pattern_gen: output voltage command from output frequency, v/f curve
// assumes out_freq and settings are on sys_clk; terminal pins are asynchronous
`timescale 1ns/10ps
`default_nettype none

// Operation
// [R01] base frequency setpoint 0..400 hz, reset 50 hz, reaches base voltage
// [R02] base voltage setpoint 0..1000 v caps maximum output voltage
// [R03] base voltage code 8888, reset value, means 95 % of supply
// [R04] base voltage code 9999 means the supply voltage itself
// [R05] output voltage command never exceeds the supply voltage
// [R06] second function selects second base frequency; 9999 disables it
// [R07] flux vector modes use motor rated voltage and frequency instead
// [R08] s-pattern a uses the active base frequency as inflection point; code takes fb_set, so flux vector modes keep the set base frequency
// [R09] load pattern codes 0..3, reset 0
// [R10] pattern 0: voltage linear in frequency up to base frequency
// [R11] pattern 1: voltage square of frequency up to base frequency
// [R12] pattern 2: boost forward, zero boost in reverse
// [R13] pattern 3: zero boost forward, boost in reverse
// [R14] second function selects second torque boost
// [R15] load pattern ignored under flux vector modes
// [R16] second function comes from a terminal assigned code 3
// [R17] second function enables all second-set functions together
// [R18] base voltage, second base freq, load pattern writable only in group 0
// [R19] above base frequency voltage stays at base voltage
// [R20] recompute on change of frequency, direction or second function
module vfp_pattern_gen
   import vfp_pkg::*;
(
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // setting write port
   input wire vfp_wr_t cfg_wr,
   input wire logic [SET_W-1:0] user_group_read_select,
   // fixed settings
   input wire logic [BOOST_W-1:0] primary_torque_boost,
   input wire logic [BOOST_W-1:0] second_torque_boost,
   input wire logic [1:0] accel_pattern_select,
   input wire logic [SET_W-1:0] motor_rated_voltage,
   input wire logic [SET_W-1:0] motor_rated_frequency,
   input wire logic flux_vector_mode,
   input wire logic [TERM_N-1:0][ASSIGN_W-1:0] input_terminal_function_assign,
   // drive side
   input wire logic [TERM_N-1:0] term_pin,
   input wire logic [FREQ_W-1:0] out_freq,
   input wire logic rev_dir,
   input wire logic [SET_W-1:0] supply_voltage,
   // results
   output vfp_cfg_t cfg_state,
   output logic cfg_refused,
   output logic [SET_W-1:0] volt_cmd,
   output logic [BOOST_W-1:0] boost_cmd,
   output logic [SET_W-1:0] s_inflect_freq,
   output logic s_inflect_en,
   output logic second_set_active,
   output logic calc_busy
);

   vfp_cfg_t cfg_reg;
   logic [TERM_N-1:0] pin_meta_reg;
   logic [TERM_N-1:0] pin_sync_reg;
   logic sec_reg;
   logic refused_reg;
   logic dirty_reg;
   vfp_state_t state_reg;
   logic [FREQ_W-1:0] last_f_reg;
   logic last_dir_reg;
   logic last_sec_reg;
   logic [SET_W-1:0] snap_vb_reg;
   logic [1:0] snap_load_reg;
   logic snap_vec_reg;
   logic [SET_W-1:0] snap_vsup_reg;
   logic [SET_W-1:0] fb_reg;
   logic [SET_W:0] rem_reg;
   logic [RATIO_W-1:0] ratio_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [SET_W-1:0] volt_reg;
   logic [BOOST_W-1:0] boost_reg;
   logic [SET_W-1:0] infl_reg;
   logic infl_en_reg;
   logic busy_reg;

   logic sec_next;
   logic wr_ok;
   logic wr_locked;
   logic wr_range_ok;
   logic [SET_W-1:0] fb_set;
   logic [SET_W-1:0] fb_act;
   logic [SET_W-1:0] vb_act;
   logic [SET_W+7:0] vsup_95;
   logic changed;
   logic [SET_W:0] rem_sh;
   logic [SET_W+RATIO_W-1:0] lin_prod;
   logic [2*RATIO_W-1:0] sq_prod;
   logic [RATIO_W-1:0] ratio_sq;
   logic [SET_W+RATIO_W-1:0] sq_vprod;
   logic [SET_W-1:0] volt_next;
   logic [BOOST_W-1:0] boost_sel;
   logic [BOOST_W-1:0] boost_next;

   // two-stage synchroniser for the terminal pins
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end else if (clk_en) begin
         pin_meta_reg <= term_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // second function from any terminal carrying the second-set code
   always_comb begin
      sec_next = 1'b0;
      for (int i = 0; i < TERM_N; i++) begin
         if (input_terminal_function_assign[i] == FUNC_SECOND && pin_sync_reg[i]) begin
            sec_next = 1'b1; // see [R16]
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sec_reg <= 1'b0;
      end else if (clk_en) begin
         sec_reg <= sec_next; // see [R17]
      end
   end

   // write checks: group lock and setting range
   always_comb begin
      wr_locked = (cfg_wr.sel != ADDR_BASE_FREQ) && (user_group_read_select != GRP_ALL); // see [R18]
      unique case (cfg_wr.sel)
         ADDR_BASE_FREQ: wr_range_ok = cfg_wr.data <= FREQ_MAX; // see [R01]
         ADDR_BASE_VOLT: wr_range_ok = (cfg_wr.data <= VOLT_MAX) || (cfg_wr.data == CODE_95PCT)
            || (cfg_wr.data == CODE_9999); // see [R02]
         ADDR_SEC_FREQ: wr_range_ok = (cfg_wr.data <= FREQ_MAX) || (cfg_wr.data == CODE_9999); // see [R06]
         ADDR_LOAD: wr_range_ok = cfg_wr.data[SET_W-1:2] == '0; // see [R09]
      endcase
      wr_ok = cfg_wr.wr && !wr_locked && wr_range_ok;
   end

   // setting storage
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_reg.base_freq_setpoint <= BASE_FREQ_RST; // see [R01]
         cfg_reg.base_voltage_setpoint <= BASE_VOLT_RST; // see [R03]
         cfg_reg.second_base_freq_setpoint <= SEC_FREQ_RST;
         cfg_reg.load_pattern_select <= LOAD_RST; // see [R09]
      end else if (clk_en && wr_ok) begin
         unique case (cfg_wr.sel)
            ADDR_BASE_FREQ: cfg_reg.base_freq_setpoint <= cfg_wr.data;
            ADDR_BASE_VOLT: cfg_reg.base_voltage_setpoint <= cfg_wr.data;
            ADDR_SEC_FREQ: cfg_reg.second_base_freq_setpoint <= cfg_wr.data;
            ADDR_LOAD: cfg_reg.load_pattern_select <= cfg_wr.data[1:0];
         endcase
      end
   end

   // refused write flag, one cycle
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         refused_reg <= 1'b0;
      end else if (clk_en) begin
         refused_reg <= cfg_wr.wr && !wr_ok;
      end
   end

   // active base frequency and base voltage
   always_comb begin
      vsup_95 = ({8'h00, supply_voltage} * {{SET_W{1'b0}}, PCT_NUM}) / {{SET_W{1'b0}}, PCT_DEN};
      if (sec_reg && cfg_reg.second_base_freq_setpoint != CODE_9999) begin
         fb_set = cfg_reg.second_base_freq_setpoint; // see [R06]
      end else begin
         fb_set = cfg_reg.base_freq_setpoint;
      end
      if (flux_vector_mode) begin
         fb_act = motor_rated_frequency; // see [R07]
         vb_act = motor_rated_voltage;
      end else begin
         fb_act = fb_set;
         if (cfg_reg.base_voltage_setpoint == CODE_95PCT) begin
            vb_act = vsup_95[SET_W-1:0]; // see [R03]
         end else if (cfg_reg.base_voltage_setpoint == CODE_9999) begin
            vb_act = supply_voltage; // see [R04]
         end else begin
            vb_act = cfg_reg.base_voltage_setpoint; // see [R02]
         end
      end
   end

   // a change in frequency, direction, second function, supply, mode or settings restarts the curve
   assign changed = (out_freq != last_f_reg) || (rev_dir != last_dir_reg) || (sec_reg != last_sec_reg)
      || (supply_voltage != snap_vsup_reg) || (flux_vector_mode != snap_vec_reg) || dirty_reg; // see [R20] [R05]

   // dirty flag: a write landing on the start cycle is kept
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dirty_reg <= 1'b1;
      end else if (clk_en) begin
         if (wr_ok) begin
            dirty_reg <= 1'b1;
         end else if (state_reg == ST_IDLE) begin
            dirty_reg <= 1'b0;
         end
      end
   end

   // shift-subtract step of the frequency ratio divider
   assign rem_sh = {rem_reg[SET_W-1:0], 1'b0};

   // sequencer: snapshot, divide, deliver
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         last_f_reg <= '0;
         last_dir_reg <= 1'b0;
         last_sec_reg <= 1'b0;
         snap_vb_reg <= '0;
         snap_load_reg <= LOAD_RST;
         snap_vec_reg <= 1'b0;
         snap_vsup_reg <= '0;
         fb_reg <= '0;
         rem_reg <= '0;
         ratio_reg <= '0;
         cnt_reg <= '0;
         busy_reg <= 1'b0;
      end else if (clk_en) begin
         busy_reg <= (state_reg == ST_IDLE) ? changed : (state_reg == ST_DIV); // busy flop mirrors next state
         unique case (state_reg)
            ST_IDLE: begin
               if (changed) begin
                  last_f_reg <= out_freq;
                  last_dir_reg <= rev_dir;
                  last_sec_reg <= sec_reg;
                  snap_vb_reg <= vb_act;
                  snap_load_reg <= cfg_reg.load_pattern_select;
                  snap_vec_reg <= flux_vector_mode;
                  snap_vsup_reg <= supply_voltage;
                  fb_reg <= fb_act;
                  ratio_reg <= '0;
                  cnt_reg <= DIV_STEPS;
                  if (fb_act == '0 || out_freq >= {2'b00, fb_act}) begin
                     ratio_reg <= RATIO_FULL; // see [R19]
                     state_reg <= ST_OUT;
                  end else begin
                     rem_reg <= {1'b0, out_freq[SET_W-1:0]};
                     state_reg <= ST_DIV;
                  end
               end
            end
            ST_DIV: begin
               if (rem_sh >= {1'b0, fb_reg}) begin
                  rem_reg <= rem_sh - {1'b0, fb_reg};
                  ratio_reg <= {ratio_reg[RATIO_W-2:0], 1'b1};
               end else begin
                  rem_reg <= rem_sh;
                  ratio_reg <= {ratio_reg[RATIO_W-2:0], 1'b0};
               end
               cnt_reg <= cnt_reg - 4'h1;
               if (cnt_reg == '0) begin
                  state_reg <= ST_OUT;
               end
            end
            ST_OUT: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // curve shape and supply clamp
   always_comb begin
      lin_prod = {{RATIO_W{1'b0}}, snap_vb_reg} * {{SET_W{1'b0}}, ratio_reg};
      sq_prod = {{RATIO_W{1'b0}}, ratio_reg} * {{RATIO_W{1'b0}}, ratio_reg};
      ratio_sq = sq_prod[FRAC_W+RATIO_W-1:FRAC_W];
      sq_vprod = {{RATIO_W{1'b0}}, snap_vb_reg} * {{SET_W{1'b0}}, ratio_sq};
      if (snap_load_reg == LOAD_SQUARE && !snap_vec_reg) begin
         volt_next = sq_vprod[FRAC_W+SET_W-1:FRAC_W]; // see [R11] [R15]
      end else begin
         volt_next = lin_prod[FRAC_W+SET_W-1:FRAC_W]; // see [R10] [R19]
      end
      if (volt_next > snap_vsup_reg) begin
         volt_next = snap_vsup_reg; // see [R05]
      end
   end

   // torque boost by set and direction
   always_comb begin
      boost_sel = last_sec_reg ? second_torque_boost : primary_torque_boost; // see [R14]
      boost_next = boost_sel;
      if (!snap_vec_reg) begin
         if (snap_load_reg == LOAD_LIFT_FWD && last_dir_reg) begin
            boost_next = '0; // see [R12]
         end else if (snap_load_reg == LOAD_LIFT_REV && !last_dir_reg) begin
            boost_next = '0; // see [R13]
         end
      end
   end

   // delivered results
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         volt_reg <= '0;
         boost_reg <= '0;
      end else if (clk_en && state_reg == ST_OUT) begin
         volt_reg <= volt_next;
         boost_reg <= boost_next;
      end
   end

   // s-curve inflection point from the setting base frequency
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         infl_reg <= '0;
         infl_en_reg <= 1'b0;
      end else if (clk_en) begin
         infl_en_reg <= accel_pattern_select == ACCEL_S_A; // see [R08]
         infl_reg <= (accel_pattern_select == ACCEL_S_A) ? fb_set : '0;
      end
   end

   // outputs straight from flops
   assign cfg_state = cfg_reg;
   assign cfg_refused = refused_reg;
   assign volt_cmd = volt_reg;
   assign boost_cmd = boost_reg;
   assign s_inflect_freq = infl_reg;
   assign s_inflect_en = infl_en_reg;
   assign second_set_active = sec_reg;
   assign calc_busy = busy_reg;

endmodule

`default_nettype wire

/* File: rtl/vfp_pkg.sv */
// vfp_pkg: constants, codes and carrier types of the v/f pattern generator
// assumes frequencies in 0.1 hz steps, voltages in whole volts, boost in 0.1 %
package vfp_pkg;
   // widths
   localparam int unsigned SET_W = 14;
   localparam int unsigned FREQ_W = 16;
   localparam int unsigned BOOST_W = 10;
   localparam int unsigned ASSIGN_W = 8;
   localparam int unsigned TERM_N = 7;
   localparam int unsigned FRAC_W = 12;
   localparam int unsigned RATIO_W = FRAC_W + 1;
   localparam int unsigned CNT_W = 4;
   // setpoint limits and special codes
   localparam logic [SET_W-1:0] FREQ_MAX = 14'h0fa0;      // 400.0 hz
   localparam logic [SET_W-1:0] VOLT_MAX = 14'h03e8;      // 1000 v
   localparam logic [SET_W-1:0] CODE_95PCT = 14'h22b8;    // 8888
   localparam logic [SET_W-1:0] CODE_9999 = 14'h270f;     // 9999
   localparam logic [SET_W-1:0] GRP_ALL = 14'h0000;       // user group read select 0
   localparam logic [7:0] PCT_NUM = 8'h5f;                // 95
   localparam logic [7:0] PCT_DEN = 8'h64;                // 100
   // reset values
   localparam logic [SET_W-1:0] BASE_FREQ_RST = 14'h01f4; // 50.0 hz
   localparam logic [SET_W-1:0] BASE_VOLT_RST = CODE_95PCT;
   localparam logic [SET_W-1:0] SEC_FREQ_RST = CODE_9999;
   localparam logic [1:0] LOAD_RST = 2'h0;
   // write select codes of the setting port
   localparam logic [1:0] ADDR_BASE_FREQ = 2'h0;
   localparam logic [1:0] ADDR_BASE_VOLT = 2'h1;
   localparam logic [1:0] ADDR_SEC_FREQ = 2'h2;
   localparam logic [1:0] ADDR_LOAD = 2'h3;
   // load pattern, accel pattern and terminal function codes, divider constants
   localparam logic [1:0] LOAD_LINEAR = 2'h0;
   localparam logic [1:0] LOAD_SQUARE = 2'h1;
   localparam logic [1:0] LOAD_LIFT_FWD = 2'h2;
   localparam logic [1:0] LOAD_LIFT_REV = 2'h3;
   localparam logic [1:0] ACCEL_S_A = 2'h1;
   localparam logic [ASSIGN_W-1:0] FUNC_SECOND = 8'h03;
   localparam logic [RATIO_W-1:0] RATIO_FULL = 13'h1000;
   localparam logic [CNT_W-1:0] DIV_STEPS = 4'hb;          // twelve quotient bits

   // stored settings
   typedef struct packed {
      logic [SET_W-1:0] base_freq_setpoint;
      logic [SET_W-1:0] base_voltage_setpoint;
      logic [SET_W-1:0] second_base_freq_setpoint;
      logic [1:0] load_pattern_select;
   } vfp_cfg_t;

   // setting write request
   typedef struct packed {
      logic wr;
      logic [1:0] sel;
      logic [SET_W-1:0] data;
   } vfp_wr_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DIV = 2'b01,
      ST_OUT = 2'b10
   } vfp_state_t;
endpackage

/* File: sim/vfp_pattern_gen_sva.sv */
// vfp_pattern_gen_sva: port checker of the v/f pattern generator
// assumes one clock domain, bound to every vfp_pattern_gen
`timescale 1ns/10ps
`default_nettype none
module vfp_pattern_gen_sva
   import vfp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // watched ports
   input wire logic clk_en,
   input wire vfp_wr_t cfg_wr,
   input wire logic [SET_W-1:0] user_group_read_select,
   input wire logic [1:0] accel_pattern_select,
   input wire logic flux_vector_mode,
   input wire logic [TERM_N-1:0][ASSIGN_W-1:0] input_terminal_function_assign,
   input wire logic [TERM_N-1:0] term_pin,
   input wire logic rev_dir,
   input wire logic [SET_W-1:0] supply_voltage,
   input wire vfp_cfg_t cfg_state,
   input wire logic cfg_refused,
   input wire logic [SET_W-1:0] volt_cmd,
   input wire logic [BOOST_W-1:0] boost_cmd,
   input wire logic s_inflect_en,
   input wire logic second_set_active,
   input wire logic calc_busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // write to a locked setting
   sequence s_locked_wr;
      clk_en && cfg_wr.wr && cfg_wr.sel != ADDR_BASE_FREQ && user_group_read_select != GRP_ALL;
   endsequence
   // second function pin held through the synchroniser
   sequence s_sec_pin;
      (clk_en && term_pin[0] && input_terminal_function_assign[0] == FUNC_SECOND) [*3];
   endsequence
   // result lands with boost gated off by direction
   property p_lift(pat, dir);
      $fell(calc_busy) && !flux_vector_mode && cfg_state.load_pattern_select == pat && rev_dir == dir
         |-> boost_cmd == '0;
   endproperty
   a_lock_refuses: assert property (s_locked_wr |=> cfg_refused && $stable(cfg_state))
      else $error("locked write not refused");
   a_freq_write_lands: assert property (clk_en && cfg_wr.wr && cfg_wr.sel == ADDR_BASE_FREQ
      && cfg_wr.data <= FREQ_MAX |=> !cfg_refused && cfg_state.base_freq_setpoint == $past(cfg_wr.data))
      else $error("base frequency write lost");
   a_volt_range: assert property (clk_en && cfg_wr.wr && cfg_wr.sel == ADDR_BASE_VOLT
      && cfg_wr.data > VOLT_MAX && cfg_wr.data != CODE_95PCT && cfg_wr.data != CODE_9999 |=> cfg_refused)
      else $error("bad base voltage accepted");
   a_busy_bounded: assert property ($rose(calc_busy) |-> ##[1:13] !calc_busy)
      else $error("computation overran");
   a_volt_clamp: assert property ($fell(calc_busy) && $stable(supply_voltage) |-> volt_cmd <= supply_voltage)
      else $error("voltage above supply");
   a_lift_fwd: assert property (p_lift(LOAD_LIFT_FWD, 1'b1))
      else $error("boost not zero in reverse");
   a_lift_rev: assert property (p_lift(LOAD_LIFT_REV, 1'b0))
      else $error("boost not zero in forward");
   a_second_sync: assert property (s_sec_pin |=> second_set_active)
      else $error("second function not taken");
   a_inflect_on: assert property ((clk_en && accel_pattern_select == ACCEL_S_A) [*3] |-> s_inflect_en)
      else $error("inflection point not enabled");
endmodule
bind vfp_pattern_gen vfp_pattern_gen_sva u_sva (.sys_clk, .sys_rst, .clk_en, .cfg_wr, .user_group_read_select,
   .accel_pattern_select, .flux_vector_mode, .input_terminal_function_assign, .term_pin, .rev_dir,
   .supply_voltage, .cfg_state, .cfg_refused, .volt_cmd, .boost_cmd, .s_inflect_en, .second_set_active,
   .calc_busy);
`default_nettype wire

/* File: sim/vfp_pattern_gen_tb.sv */
// vfp_pattern_gen_tb: self-checking bench of the v/f pattern generator
// assumes the checker is bound and the power stage model is compiled
`timescale 1ns/10ps
`default_nettype none
module vfp_pattern_gen_tb
   import vfp_pkg::*;
;
   logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, rev_dir = 1'b0, fvm = 1'b0, sag = 1'b0, sec = 1'b0;
   logic refused, sie, ssa, busy;
   logic [1:0] accel = 2'h0;
   logic [SET_W-1:0] grp = '0, rv = 14'h00c8, rf = 14'h0258, vc, supply, applied, sif;
   logic [SET_W-1:0] vlist [4] = '{CODE_9999, 14'h01f4, 14'h012c, CODE_95PCT};
   logic [BOOST_W-1:0] pb = 10'h01e, sb = 10'h032, bc;
   logic [TERM_N-1:0][ASSIGN_W-1:0] asg = '0;
   logic [TERM_N-1:0] pins = '0;
   logic [FREQ_W-1:0] freq = '0;
   logic [31:0] seed = 32'h7c06;
   vfp_wr_t wr = '0;
   vfp_cfg_t cfg;
   int mismatches = 0, comparisons = 0, cycles = 0, i;
   vfp_pattern_gen DUT (.sys_clk, .sys_rst, .clk_en, .cfg_wr(wr), .user_group_read_select(grp),
      .primary_torque_boost(pb), .second_torque_boost(sb), .accel_pattern_select(accel),
      .motor_rated_voltage(rv), .motor_rated_frequency(rf), .flux_vector_mode(fvm),
      .input_terminal_function_assign(asg), .term_pin(pins), .out_freq(freq), .rev_dir, .supply_voltage(supply),
      .cfg_state(cfg), .cfg_refused(refused), .volt_cmd(vc), .boost_cmd(bc), .s_inflect_freq(sif),
      .s_inflect_en(sie), .second_set_active(ssa), .calc_busy(busy));
   vfp_power_stage PS (.sys_clk, .sys_rst, .sag, .volt_cmd(vc), .calc_busy(busy), .supply_voltage(supply),
      .applied_volt(applied));
   // clock and cycle ceiling
   always #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [SET_W-1:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // wait for six idle cycles in a row
   task automatic settle;
      int idle;
      idle = 0;
      for (int k = 0; k < 300 && idle < 6; k++) begin
         @(negedge sys_clk);
         idle = (busy === 1'b0) ? idle + 1 : 0;
      end
   endtask
   // one setting write, its refusal flag, then quiet
   task automatic put(input logic [1:0] sel, input logic [SET_W-1:0] d, input logic rexp);
      @(negedge sys_clk);
      wr <= '{1'b1, sel, d};
      @(negedge sys_clk);
      wr.wr <= 1'b0;
      cmp(SET_W'(refused), SET_W'(rexp));
      settle();
   endtask
   // expected voltage command of the current point
   function automatic logic [SET_W-1:0] exp_v(input logic [1:0] pat, input logic [SET_W-1:0] fb, vcode);
      logic [31:0] vb, r, b;
      b = fvm ? rf : fb;
      vb = fvm ? rv : (vcode == CODE_95PCT) ? supply * 95 / 100 : (vcode == CODE_9999) ? supply : vcode;
      if (freq < b && b != 0) begin
         r = freq * 4096 / b;
         if (pat == LOAD_SQUARE && !fvm) r = r * r / 4096;
         vb = vb * r / 4096;
      end
      return (vb > supply) ? supply : vb[SET_W-1:0];
   endfunction
   // expected boost of the current point
   function automatic logic [BOOST_W-1:0] exp_b(input logic [1:0] pat);
      if (!fvm && ((pat == LOAD_LIFT_FWD && rev_dir) || (pat == LOAD_LIFT_REV && !rev_dir))) return '0;
      return sec ? sb : pb;
   endfunction
   task automatic chk(input logic [1:0] pat, input logic [SET_W-1:0] fb, vcode);
      settle();
      cmp(vc, exp_v(pat, fb, vcode));
      cmp(SET_W'(bc), SET_W'(exp_b(pat)));
      cmp(applied, exp_v(pat, fb, vcode));
   endtask
   // main sequence
   initial begin
      repeat (8) @(negedge sys_clk);
      sys_rst = 1'b0;
      cmp(cfg.base_freq_setpoint, BASE_FREQ_RST);
      cmp(cfg.base_voltage_setpoint, CODE_95PCT);
      cmp(cfg.second_base_freq_setpoint, CODE_9999);
      cmp(SET_W'(cfg.load_pattern_select), 14'h0000);
      $display("test reset done");
      for (i = 0; i < 30; i++) begin
         put(ADDR_LOAD, SET_W'(i % 2), 1'b0);
         freq = (i < 2) ? 16'h01f4 : (i < 4) ? 16'h01f3 : 16'($unsigned($random(seed)) % 6000);
         chk(2'(i % 2), 14'h01f4, CODE_95PCT);
      end
      $display("test curves done");
      for (i = 0; i < 8; i++) begin
         sag <= i[0];
         put(ADDR_BASE_VOLT, vlist[i / 2], 1'b0);
         freq = 16'($unsigned($random(seed)) % 6000);
         chk(LOAD_LINEAR, 14'h01f4, vlist[i / 2]);
      end
      // supply change alone must restart the curve
      sag <= 1'b0;
      chk(LOAD_LINEAR, 14'h01f4, CODE_95PCT);
      $display("test base voltage done");
      put(ADDR_BASE_VOLT, 14'h03e9, 1'b1);
      put(ADDR_BASE_VOLT, 14'h22b7, 1'b1);
      put(ADDR_BASE_FREQ, 14'h0fa1, 1'b1);
      put(ADDR_SEC_FREQ, 14'h0fa1, 1'b1);
      put(ADDR_LOAD, 14'h0004, 1'b1);
      grp = 14'h0001;
      for (i = 1; i < 4; i++) put(2'(i), 14'h0000, 1'b1);
      put(ADDR_BASE_FREQ, FREQ_MAX, 1'b0);
      cmp(SET_W'(cfg.load_pattern_select), 14'h0001);
      grp = '0;
      put(ADDR_BASE_FREQ, 14'h01f4, 1'b0);
      $display("test refusals done");
      put(ADDR_SEC_FREQ, 14'h012c, 1'b0);
      asg[0] = FUNC_SECOND;
      pins[0] = 1'b1;
      sec = 1'b1;
      settle();
      cmp(SET_W'(ssa), 14'h0001);
      for (i = 0; i < 8; i++) begin
         put(ADDR_LOAD, SET_W'(2 + i % 2), 1'b0);
         rev_dir = i[1];
         freq = 16'($unsigned($random(seed)) % 6000);
         chk(2'(2 + i % 2), i[2] ? 14'h01f4 : 14'h012c, CODE_95PCT);
         if (i == 3) put(ADDR_SEC_FREQ, CODE_9999, 1'b0);
      end
      asg[0] = 8'h02;
      sec = 1'b0;
      settle();
      cmp(SET_W'(ssa), 14'h0000);
      $display("test second set done");
      fvm = 1'b1;
      for (i = 0; i < 6; i++) begin
         put(ADDR_LOAD, SET_W'(i % 4), 1'b0);
         rev_dir = i[0];
         freq = 16'($unsigned($random(seed)) % 1200);
         chk(2'(i % 4), 14'h01f4, CODE_95PCT);
      end
      fvm = 1'b0;
      $display("test vector mode done");
      accel = ACCEL_S_A;
      settle();
      cmp(sif, 14'h01f4);
      cmp(SET_W'(sie), 14'h0001);
      accel = 2'h0;
      settle();
      cmp(SET_W'(sie), 14'h0000);
      // a low clock enable freezes the flag until released
      clk_en = 1'b0;
      accel = ACCEL_S_A;
      repeat (4) @(negedge sys_clk);
      cmp(SET_W'(sie), 14'h0000);
      clk_en = 1'b1;
      settle();
      cmp(SET_W'(sie), 14'h0001);
      $display("test inflection done");
      close_out();
   end
endmodule
`default_nettype wire

/* File: sim/vfp_power_stage.sv */
// vfp_power_stage: power stage model fed by the voltage command
// assumes the bench picks a nominal or a sagging supply
`timescale 1ns/10ps
`default_nettype none
module vfp_power_stage
   import vfp_pkg::*;
(
   // clock, reset, supply choice
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sag,
   // command in, supply and applied voltage out
   input wire logic [SET_W-1:0] volt_cmd,
   input wire logic calc_busy,
   output logic [SET_W-1:0] supply_voltage,
   output logic [SET_W-1:0] applied_volt
);
   // supply moves only on the falling edge
   always_ff @(negedge sys_clk) supply_voltage <= sag ? 14'h00e6 : 14'h0190;
   // bridge takes only a settled command, cleared by reset
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         applied_volt <= '0;
      end else if (!calc_busy) begin
         applied_volt <= volt_cmd;
      end
   end
endmodule
`default_nettype wire
